// ### rtl/byte_ram.sv
`timescale 1ns/10ps
module byte_ram #(
	parameter int ADDR_WIDTH = 8,
	parameter int DATA_WIDTH = 8,
	parameter int DEPTH      = 256
) (
	input  wire logic    pclk,
	ram_port_if.memory   port
);
	logic [DATA_WIDTH-1:0] mem [DEPTH];

	generate
		if (DEPTH != (1 << ADDR_WIDTH)) begin : g_bad_depth
			$error("byte_ram depth must fill the address range");
		end
	endgenerate

	// Contents are not reset, as in the real array
	always_ff @(posedge pclk) begin
		if (port.we) begin
			mem[port.addr] <= port.wdata;
		end
	end

	assign port.rdata = mem[port.addr];
endmodule

// ### rtl/data_memory_access_unit.sv
// How it works
// - With external select high, no program address or data appears on bus.
// - Program strobe low while low port is released for external code bytes.
// - Fetches from internal program memory never pulse the program strobe.
// - Address latch strobe marks the low address byte on the multiplexed port.
// - Address latch strobe runs at one sixth of the oscillator rate.
// - Reset pin high for two machine cycles resets the device.
// - High port carries upper address on bus cycles except bank-pointer moves, else the port latch with ones pulled up.
// - 512 bytes inside: a 256-byte scratchpad plus a 256-byte auxiliary bank.
// - Scratchpad 00-7f reachable directly and through bank pointers.
// - Scratchpad 80-ff reachable only through bank pointers.
// - Auxiliary bank reached by external data moves, bank pointer or 16-bit.
// - External data moves above ff still run an external bus cycle.
// - Any reset disables the auxiliary bank.
// - Bit 4 of chip control enables the auxiliary bank.
// - Enabled bank makes every bank-pointer external data move go inside.
// - Auxiliary accesses leave ports and strobes untouched.
// - Oscillator is divided by two before use.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
module data_memory_access_unit #(
	parameter int HOLD_MACHINE_CYCLES = mem_access_pkg::RESET_MACHINE_CYCLES
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        reset_pin,
	input  wire logic        external_access_select,
	input  wire logic        core_req,
	input  wire logic [2:0]  core_kind,
	input  wire logic [15:0] core_addr,
	input  wire logic [7:0]  core_wdata,
	input  wire logic        core_via_bank_pointer,
	output logic             core_busy,
	output logic             core_done,
	output logic             core_error,
	output logic      [7:0]  core_rdata,
	output logic             device_reset,
	output logic             address_latch_strobe,
	output logic             program_store_strobe_n,
	output logic             read_strobe_n,
	output logic             write_strobe_n,
	input  wire logic [7:0]  low_address_data_port_in,
	output logic      [7:0]  low_address_data_port_out,
	output logic             low_address_data_port_oe_n,
	input  wire logic [7:0]  high_address_port_in,
	output logic      [7:0]  high_address_port_out,
	output logic      [7:0]  high_address_port_oe_n
);
	localparam int HOLD_OSC  = HOLD_MACHINE_CYCLES
		* mem_access_pkg::OSC_PER_MACHINE;
	localparam int HOLD_W    = $clog2(HOLD_OSC + 1);
	localparam logic [HOLD_W-1:0] HOLD_COUNT = HOLD_W'(HOLD_OSC);
	localparam int BUS_WAIT_MAX = 12;

	generate
		if (HOLD_MACHINE_CYCLES < 1) begin : g_bad_hold
			$error("reset hold must be at least one machine cycle");
		end
	endgenerate

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_LOCAL  = 3'b001,
		ST_WAIT   = 3'b010,
		ST_ADDR   = 3'b011,
		ST_STROBE = 3'b100
	} unit_state_type;

	unit_state_type                     state;
	unit_state_type                     next_state;
	mem_access_pkg::access_kind_type    cur_kind;
	mem_access_pkg::unlock_stage_type   unlock_stage;
	logic [15:0]       cur_addr;
	logic [7:0]        cur_wdata;
	logic              cur_on_bus;
	logic              cur_use_high;
	logic              cur_aux;
	logic              phase;
	logic [2:0]        mstate;
	logic [2:0]        next_mstate;
	logic [HOLD_W-1:0] reset_count;
	logic [7:0]        chip_control;
	logic [7:0]        high_port_latch;
	logic              aux_enable;
	logic              unlocked;
	logic              accept;
	logic              is_xdata;
	logic              is_write;
	logic              direct_bad;
	logic              go_aux;
	logic              go_bus;
	logic              slot_next;
	logic              strobe_end;
	logic              drive_addr;
	logic              in_strobe;
	logic              finish;
	logic              apb_setup;
	logic              apb_write;
	logic [9:0]        reg_index;
	logic              reg_hit;
	logic [7:0]        read_byte;
	logic [7:0]        status;

	ram_port_if scratch_port ();
	ram_port_if aux_port ();

	byte_ram scratch_ram (
		.pclk (pclk),
		.port (scratch_port.memory)
	);

	byte_ram aux_ram (
		.pclk (pclk),
		.port (aux_port.memory)
	);

	assign aux_enable = chip_control[mem_access_pkg::AUX_ENABLE_BIT];
	assign unlocked   = (unlock_stage == mem_access_pkg::UNLOCK_OPEN);

	// Oscillator halved into machine states of two clocks each
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= 1'b0;
		end else begin
			phase <= ~phase;
		end
	end

	always_comb begin
		next_mstate = mstate;
		if (phase) begin
			next_mstate = (mstate == mem_access_pkg::LAST_STATE) ? 3'h0
				: 3'(mstate + 3'h1);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// Starts in the last state so the first latch pulse is full length
			mstate <= mem_access_pkg::LAST_STATE;
		end else begin
			mstate <= next_mstate;
		end
	end

	// Latch strobe runs free, two of every six clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			address_latch_strobe <= 1'b0;
		end else begin
			address_latch_strobe <=
				(next_mstate == mem_access_pkg::ADDR_STATE_A) ||
				(next_mstate == mem_access_pkg::ADDR_STATE_B);
		end
	end

	// Short pulses on the pin never reach the count, which filters glitches
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_count  <= '0;
			device_reset <= 1'b0;
		end else begin
			if (!reset_pin) begin
				reset_count <= '0;
			end else if (reset_count != HOLD_COUNT) begin
				reset_count <= HOLD_W'(reset_count + 1'b1);
			end
			device_reset <= reset_pin && (reset_count == HOLD_COUNT);
		end
	end

	// Request decode
	assign is_xdata   = (core_kind == mem_access_pkg::KIND_XDATA_READ) ||
		(core_kind == mem_access_pkg::KIND_XDATA_WRITE);
	assign accept     = (state == ST_IDLE) && core_req && !device_reset;
	assign go_aux     = is_xdata && aux_enable && (core_via_bank_pointer ||
		core_addr[15:8] == mem_access_pkg::AUX_PAGE);
	assign go_bus     = (core_kind == mem_access_pkg::KIND_FETCH)
		? !external_access_select
		: (is_xdata && !go_aux);
	assign is_write   = (cur_kind == mem_access_pkg::KIND_DIRECT_WRITE) ||
		(cur_kind == mem_access_pkg::KIND_INDIRECT_WRITE) ||
		(cur_kind == mem_access_pkg::KIND_XDATA_WRITE);
	assign direct_bad = ((cur_kind == mem_access_pkg::KIND_DIRECT_READ) ||
		(cur_kind == mem_access_pkg::KIND_DIRECT_WRITE)) &&
		(cur_addr[7:0] > mem_access_pkg::DIRECT_TOP);
	assign slot_next  = phase && ((mstate == mem_access_pkg::LAST_STATE) ||
		(mstate == mem_access_pkg::STROBE_END_A));
	assign strobe_end = phase && ((mstate == mem_access_pkg::STROBE_END_A) ||
		(mstate == mem_access_pkg::STROBE_END_B));
	assign finish     = (state == ST_LOCAL) ||
		((state == ST_STROBE) && strobe_end);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_kind     <= mem_access_pkg::KIND_FETCH;
			cur_addr     <= 16'h0000;
			cur_wdata    <= 8'h00;
			cur_on_bus   <= 1'b0;
			cur_use_high <= 1'b0;
			cur_aux      <= 1'b0;
		end else if (accept) begin
			cur_kind     <= mem_access_pkg::access_kind_type'(core_kind);
			cur_addr     <= core_addr;
			cur_wdata    <= core_wdata;
			cur_on_bus   <= go_bus;
			// Bank-pointer moves keep the port latch on the high pins
			cur_use_high <= go_bus && !(is_xdata && core_via_bank_pointer);
			cur_aux      <= go_aux;
		end
	end

	always_comb begin
		next_state = state;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_state = go_bus ? ST_WAIT : ST_LOCAL;
				end
			end
			ST_LOCAL: begin
				next_state = ST_IDLE;
			end
			ST_WAIT: begin
				if (slot_next) begin
					next_state = ST_ADDR;
				end
			end
			ST_ADDR: begin
				if (phase) begin
					next_state = ST_STROBE;
				end
			end
			ST_STROBE: begin
				if (strobe_end) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		if (device_reset) begin
			next_state = ST_IDLE;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= ST_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Internal banks; only the local state touches them
	always_comb begin
		scratch_port.we    = (state == ST_LOCAL) && !cur_on_bus && !cur_aux
			&& is_write && !direct_bad;
		scratch_port.addr  = cur_addr[7:0];
		scratch_port.wdata = cur_wdata;
		aux_port.we        = (state == ST_LOCAL) && cur_aux && is_write;
		aux_port.addr      = cur_addr[7:0];
		aux_port.wdata     = cur_wdata;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_busy  <= 1'b0;
			core_done  <= 1'b0;
			core_error <= 1'b0;
			core_rdata <= 8'h00;
		end else begin
			core_busy  <= (next_state != ST_IDLE);
			core_done  <= finish && !device_reset;
			core_error <= finish && direct_bad && !device_reset;
			if (state == ST_STROBE && strobe_end) begin
				core_rdata <= low_address_data_port_in;
			end else if (state == ST_LOCAL) begin
				if (cur_aux) begin
					core_rdata <= aux_port.rdata;
				end else if (cur_kind == mem_access_pkg::KIND_FETCH ||
					direct_bad) begin
					core_rdata <= 8'h00;
				end else begin
					core_rdata <= scratch_port.rdata;
				end
			end
		end
	end

	// Pins follow the next state so they change on the bus slot edges
	assign drive_addr = (next_state == ST_ADDR);
	assign in_strobe  = (next_state == ST_STROBE);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			low_address_data_port_out  <= mem_access_pkg::PORT_RELEASED;
			low_address_data_port_oe_n <= 1'b1;
		end else if (drive_addr) begin
			low_address_data_port_out  <= cur_addr[7:0];
			low_address_data_port_oe_n <= 1'b0;
		end else if (in_strobe && is_write) begin
			low_address_data_port_out  <= cur_wdata;
			low_address_data_port_oe_n <= 1'b0;
		end else begin
			// Released while reading so external data can drive it
			low_address_data_port_out  <= mem_access_pkg::PORT_RELEASED;
			low_address_data_port_oe_n <= 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_store_strobe_n <= 1'b1;
			read_strobe_n          <= 1'b1;
			write_strobe_n         <= 1'b1;
		end else begin
			program_store_strobe_n <= !(in_strobe &&
				cur_kind == mem_access_pkg::KIND_FETCH);
			read_strobe_n  <= !(in_strobe &&
				cur_kind == mem_access_pkg::KIND_XDATA_READ);
			write_strobe_n <= !(in_strobe &&
				cur_kind == mem_access_pkg::KIND_XDATA_WRITE);
		end
	end

	// Quasi-bidirectional: ones are released to the pull-ups
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_address_port_out  <= mem_access_pkg::HIGH_PORT_RESET;
			high_address_port_oe_n <= 8'hff;
		end else if ((drive_addr || in_strobe) && cur_use_high) begin
			high_address_port_out  <= cur_addr[15:8];
			high_address_port_oe_n <= 8'h00;
		end else begin
			high_address_port_out  <= high_port_latch;
			high_address_port_oe_n <= high_port_latch;
		end
	end

	// APB slave, no wait states
	assign apb_setup = psel && !penable;
	assign apb_write = psel && penable && pready && pwrite && pstrb[0];
	assign reg_index = paddr[11:2];
	assign reg_hit   = (paddr[1:0] == 2'b00) &&
		((reg_index == mem_access_pkg::CHIP_CONTROL_INDEX) ||
		(reg_index == mem_access_pkg::UNLOCK_INDEX) ||
		(reg_index == mem_access_pkg::STATUS_INDEX) ||
		(reg_index == mem_access_pkg::HIGH_PORT_INDEX));

	always_comb begin
		status = 8'h00;
		status[mem_access_pkg::STATUS_AUX_ENABLED] = aux_enable;
		status[mem_access_pkg::STATUS_UNLOCKED]    = unlocked;
		status[mem_access_pkg::STATUS_BUSY]        = core_busy;
		status[mem_access_pkg::STATUS_IN_RESET]    = device_reset;
		status[mem_access_pkg::STATUS_EXT_SELECT]  = external_access_select;
		case (reg_index)
			mem_access_pkg::CHIP_CONTROL_INDEX: read_byte = chip_control;
			mem_access_pkg::UNLOCK_INDEX:       read_byte = {7'h00, unlocked};
			mem_access_pkg::STATUS_INDEX:       read_byte = status;
			mem_access_pkg::HIGH_PORT_INDEX:    read_byte = high_address_port_in;
			default:                            read_byte = 8'h00;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !reg_hit;
			prdata  <= (apb_setup && !pwrite && reg_hit)
				? {24'h00_0000, read_byte} : 32'h0000_0000;
		end
	end

	// Any write other than the expected key relocks, except the first key, which always restarts at halfway
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			unlock_stage <= mem_access_pkg::UNLOCK_LOCKED;
		end else if (device_reset) begin
			unlock_stage <= mem_access_pkg::UNLOCK_LOCKED;
		end else if (apb_write && reg_hit &&
			reg_index == mem_access_pkg::UNLOCK_INDEX) begin
			if (pwdata[7:0] == mem_access_pkg::UNLOCK_KEY_FIRST) begin
				unlock_stage <= mem_access_pkg::UNLOCK_HALFWAY;
			end else if (pwdata[7:0] == mem_access_pkg::UNLOCK_KEY_SECOND &&
				unlock_stage == mem_access_pkg::UNLOCK_HALFWAY) begin
				unlock_stage <= mem_access_pkg::UNLOCK_OPEN;
			end else begin
				unlock_stage <= mem_access_pkg::UNLOCK_LOCKED;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chip_control <= mem_access_pkg::CHIP_CONTROL_RESET;
		end else if (device_reset) begin
			chip_control <= mem_access_pkg::CHIP_CONTROL_RESET;
		end else if (apb_write && reg_hit && unlocked &&
			reg_index == mem_access_pkg::CHIP_CONTROL_INDEX) begin
			chip_control <= pwdata[7:0] & mem_access_pkg::CHIP_CONTROL_MASK;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_port_latch <= mem_access_pkg::HIGH_PORT_RESET;
		end else if (device_reset) begin
			high_port_latch <= mem_access_pkg::HIGH_PORT_RESET;
		end else if (apb_write && reg_hit &&
			reg_index == mem_access_pkg::HIGH_PORT_INDEX) begin
			high_port_latch <= pwdata[7:0];
		end
	end

	chk_ext_select_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		(accept && core_kind == mem_access_pkg::KIND_FETCH &&
		external_access_select) |=> (!cur_on_bus &&
		program_store_strobe_n && low_address_data_port_oe_n) [*2])
		else $error("bus used while external select was high");

	chk_strobe_port_free: assert property (
		@(posedge pclk) disable iff (!presetn)
		!program_store_strobe_n |-> low_address_data_port_oe_n &&
		cur_kind == mem_access_pkg::KIND_FETCH && cur_on_bus)
		else $error("program strobe with low port driven");

	chk_internal_no_strobe: assert property (
		@(posedge pclk) disable iff (!presetn)
		(state == ST_LOCAL) |-> program_store_strobe_n ##1
		program_store_strobe_n)
		else $error("program strobe on internal access");

	chk_latch_has_addr: assert property (
		@(posedge pclk) disable iff (!presetn)
		(state == ST_ADDR) |-> address_latch_strobe &&
		!low_address_data_port_oe_n &&
		low_address_data_port_out == cur_addr[7:0])
		else $error("address missing under latch strobe");

	chk_latch_rate: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(address_latch_strobe) |=> address_latch_strobe ##1
		!address_latch_strobe [*4] ##1 address_latch_strobe)
		else $error("latch strobe not at one sixth rate");

	chk_reset_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		(reset_count != HOLD_COUNT) |=> !device_reset)
		else $error("device reset before two machine cycles");

	chk_high_port_addr: assert property (
		@(posedge pclk) disable iff (!presetn)
		(state == ST_STROBE && cur_use_high) |->
		high_address_port_out == cur_addr[15:8] &&
		high_address_port_oe_n == 8'h00)
		else $error("upper address missing on high port");

	chk_direct_upper: assert property (
		@(posedge pclk) disable iff (!presetn)
		(accept && !device_reset &&
		(core_kind == mem_access_pkg::KIND_DIRECT_READ ||
		core_kind == mem_access_pkg::KIND_DIRECT_WRITE)) |=> ##1
		(core_done && core_error == (cur_addr[7:0] > 8'h7f)))
		else $error("direct upper scratchpad not refused");

	chk_xdata_bus: assert property (
		@(posedge pclk) disable iff (!presetn || reset_pin)
		(accept && is_xdata && !go_aux) |->
		##[1:BUS_WAIT_MAX] (!read_strobe_n || !write_strobe_n))
		else $error("external data move without bus cycle");

	chk_aux_after_reset: assert property (
		@(posedge pclk) disable iff (!presetn)
		device_reset |=> !aux_enable && !unlocked)
		else $error("auxiliary bank enabled after reset");

	chk_ctrl_locked: assert property (
		@(posedge pclk) disable iff (!presetn)
		(apb_write && !unlocked &&
		reg_index == mem_access_pkg::CHIP_CONTROL_INDEX) |=>
		$stable(chip_control))
		else $error("chip control changed while locked");

	chk_aux_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		(state == ST_LOCAL && cur_aux) |-> $stable(read_strobe_n) &&
		$stable(write_strobe_n) && low_address_data_port_oe_n ##1
		$stable(low_address_data_port_out) && read_strobe_n)
		else $error("auxiliary access disturbed the bus");

	chk_state_halved: assert property (
		@(posedge pclk) disable iff (!presetn)
		(mstate != $past(mstate)) |-> !phase && $past(phase))
		else $error("machine state not on halved clock");
endmodule

// ### rtl/mem_access_pkg.sv
package mem_access_pkg;

	// Timing of the internal state sequence, counted in oscillator clocks
	localparam int OSC_PER_STATE        = 2;
	localparam int STATES_PER_MACHINE   = 6;
	localparam int OSC_PER_MACHINE      = OSC_PER_STATE * STATES_PER_MACHINE;
	localparam int RESET_MACHINE_CYCLES = 2;
	localparam int RESET_HOLD_OSC       = RESET_MACHINE_CYCLES * OSC_PER_MACHINE;

	// Last machine state, the states that carry the address phase, and the last state of each strobe
	localparam logic [2:0] LAST_STATE    = 3'h5;
	localparam logic [2:0] ADDR_STATE_A  = 3'h0;
	localparam logic [2:0] ADDR_STATE_B  = 3'h3;
	localparam logic [2:0] STROBE_END_A  = 3'h2;
	localparam logic [2:0] STROBE_END_B  = 3'h5;

	// Register indices; byte address is four times the index
	localparam logic [9:0] CHIP_CONTROL_INDEX = 10'h0bf;
	localparam logic [9:0] UNLOCK_INDEX       = 10'h0f6;
	localparam logic [9:0] STATUS_INDEX       = 10'h100;
	localparam logic [9:0] HIGH_PORT_INDEX    = 10'h101;

	localparam logic [7:0] CHIP_CONTROL_RESET = 8'h00;
	localparam logic [7:0] CHIP_CONTROL_MASK  = 8'h9f;
	localparam int         AUX_ENABLE_BIT     = 4;
	localparam logic [7:0] UNLOCK_RESET       = 8'h00;
	localparam logic [7:0] UNLOCK_KEY_FIRST   = 8'h87;
	localparam logic [7:0] UNLOCK_KEY_SECOND  = 8'h59;
	localparam logic [7:0] HIGH_PORT_RESET    = 8'hff;
	localparam logic [7:0] PORT_RELEASED      = 8'hff;

	// Address limits
	localparam logic [7:0] DIRECT_TOP = 8'h7f;
	localparam logic [7:0] AUX_PAGE   = 8'h00;

	// Status register bit positions
	localparam int STATUS_AUX_ENABLED = 0;
	localparam int STATUS_UNLOCKED    = 1;
	localparam int STATUS_BUSY        = 2;
	localparam int STATUS_IN_RESET    = 3;
	localparam int STATUS_EXT_SELECT  = 4;

	typedef enum logic [2:0] {
		KIND_FETCH          = 3'b000,
		KIND_DIRECT_READ    = 3'b001,
		KIND_DIRECT_WRITE   = 3'b010,
		KIND_INDIRECT_READ  = 3'b011,
		KIND_INDIRECT_WRITE = 3'b100,
		KIND_XDATA_READ     = 3'b101,
		KIND_XDATA_WRITE    = 3'b110
	} access_kind_type;

	typedef enum logic [1:0] {
		UNLOCK_LOCKED  = 2'b00,
		UNLOCK_HALFWAY = 2'b01,
		UNLOCK_OPEN    = 2'b10
	} unlock_stage_type;

endpackage

// ### rtl/ram_port_if.sv
`timescale 1ns/10ps
interface ram_port_if #(
	parameter int ADDR_WIDTH = 8,
	parameter int DATA_WIDTH = 8
);
	logic                  we;
	logic [ADDR_WIDTH-1:0] addr;
	logic [DATA_WIDTH-1:0] wdata;
	logic [DATA_WIDTH-1:0] rdata;

	modport owner  (output we, output addr, output wdata, input rdata);
	modport memory (input we, input addr, input wdata, output rdata);
endinterface

// ### tb/data_memory_access_unit_bench.sv
`timescale 1ns/10ps
module data_memory_access_unit_bench;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0]  pstrb = 4'hf;
	logic        reset_pin, external_access_select, core_req, e;
	logic        core_via_bank_pointer, core_busy, core_done, core_error;
	logic [2:0]  core_kind;
	logic [15:0] core_addr;
	logic [7:0]  core_wdata, core_rdata, q, d, a, mem_q;
	logic        device_reset, address_latch_strobe, program_store_strobe_n;
	logic        read_strobe_n, write_strobe_n, low_address_data_port_oe_n;
	logic [7:0]  low_address_data_port_in, low_address_data_port_out;
	logic [7:0]  high_address_port_in, high_address_port_out;
	logic [7:0]  high_address_port_oe_n;
	logic        ale_q;
	logic [7:0]  hi_q;
	int          miscompares = 0;
	int          checks = 0;
	int          seed = 52;
	int          bus_cnt = 0;
	int          ale_cnt = 0;
	int          n0;

	data_memory_access_unit i_dut (.*);
	ext_memory i_mem (.pclk(pclk), .ale(address_latch_strobe),
		.ps_n(program_store_strobe_n), .rd_n(read_strobe_n),
		.wr_n(write_strobe_n), .bus_out(low_address_data_port_out),
		.bus_in(mem_q));

	assign low_address_data_port_in = low_address_data_port_oe_n ?
		mem_q : low_address_data_port_out;
	assign high_address_port_in = high_address_port_out | high_address_port_oe_n;

	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	always @(posedge pclk) begin
		ale_q <= address_latch_strobe;
		if (!write_strobe_n)
			hi_q <= high_address_port_out;
		if (address_latch_strobe && !ale_q)
			ale_cnt <= ale_cnt + 1;
		if (!program_store_strobe_n || !read_strobe_n || !write_strobe_n ||
			!low_address_data_port_oe_n)
			bus_cnt <= bus_cnt + 1;
	end

	// Partner answers a code fetch with the latched low byte scrambled
	function automatic logic [7:0] fetch_byte(input logic [15:0] ad);
		return ad[7:0] ^ 8'hc3;
	endfunction

	task wrap_up;
		if (miscompares == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want) begin
			miscompares++;
			$display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
		end
	endtask

	task timeout;
		miscompares++;
		wrap_up;
	endtask

	task apb(input logic w, input logic [9:0] idx, input logic [7:0] wd);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		for (n = 0; n < 20 && pready !== 1'b1; n++)
			@(posedge pclk);
		if (n == 20)
			timeout;
		q = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task core(input mem_access_pkg::access_kind_type k, input logic [15:0] ad,
		input logic [7:0] wd, input logic via);
		int n;
		@(posedge pclk);
		core_req <= 1'b1;
		core_kind <= k;
		core_addr <= ad;
		core_wdata <= wd;
		core_via_bank_pointer <= via;
		@(posedge pclk);
		core_req <= 1'b0;
		for (n = 0; n < 40 && core_done !== 1'b1; n++)
			@(posedge pclk);
		if (n == 40)
			timeout;
		q = core_rdata;
		e = core_error;
	endtask

	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, reset_pin} = '0;
		{core_req, core_kind, core_addr, core_wdata} = '0;
		core_via_bank_pointer = 1'b0;
		external_access_select = 1'b1;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, mem_access_pkg::CHIP_CONTROL_INDEX, 8'h00);
		check(q, 8'h00);
		apb(0, 10'h010, 8'h00);
		check(e, 1'b1);
		repeat (6) begin
			a = 8'($random(seed));
			d = 8'($random(seed));
			core(mem_access_pkg::KIND_DIRECT_WRITE, {9'h0, a[6:0]}, d, 1'b1);
			core(mem_access_pkg::KIND_INDIRECT_READ, {9'h0, a[6:0]}, 8'h0, 1'b1);
			check(q, d);
			core(mem_access_pkg::KIND_INDIRECT_WRITE, {9'h1, a[6:0]}, ~d, 1'b0);
			core(mem_access_pkg::KIND_INDIRECT_READ, {9'h1, a[6:0]}, 8'h0, 1'b0);
			check(q, ~d);
			core(mem_access_pkg::KIND_DIRECT_READ, {9'h1, a[6:0]}, 8'h0, 1'b0);
			check(e, 1'b1);
		end
		n0 = bus_cnt;
		core(mem_access_pkg::KIND_XDATA_WRITE, 16'h0012, 8'ha5, 1'b1);
		core(mem_access_pkg::KIND_XDATA_READ, 16'h0012, 8'h00, 1'b1);
		check(q, 8'ha5);
		check(bus_cnt > n0, 1'b1);
		apb(1, mem_access_pkg::UNLOCK_INDEX, 8'h87);
		apb(1, mem_access_pkg::UNLOCK_INDEX, 8'h59);
		apb(1, mem_access_pkg::CHIP_CONTROL_INDEX, 8'h10);
		apb(1, mem_access_pkg::UNLOCK_INDEX, 8'h00);
		apb(0, mem_access_pkg::CHIP_CONTROL_INDEX, 8'h00);
		check(q, 8'h10);
		n0 = bus_cnt;
		core(mem_access_pkg::KIND_XDATA_WRITE, 16'h0012, 8'h3c, 1'b1);
		core(mem_access_pkg::KIND_XDATA_WRITE, 16'h0034, 8'h77, 1'b0);
		core(mem_access_pkg::KIND_XDATA_READ, 16'h0012, 8'h00, 1'b1);
		check(q, 8'h3c);
		core(mem_access_pkg::KIND_XDATA_READ, 16'h0034, 8'h00, 1'b1);
		check(q, 8'h77);
		check(bus_cnt == n0, 1'b1);
		core(mem_access_pkg::KIND_XDATA_WRITE, 16'h0312, 8'hc6, 1'b0);
		core(mem_access_pkg::KIND_XDATA_READ, 16'h0312, 8'h00, 1'b0);
		check(q, 8'hc6);
		check(bus_cnt > n0, 1'b1);
		check(hi_q, 8'h03);
		n0 = bus_cnt;
		core(mem_access_pkg::KIND_FETCH, 16'h1234, 8'h00, 1'b0);
		check(bus_cnt == n0, 1'b1);
		external_access_select <= 1'b0;
		core(mem_access_pkg::KIND_FETCH, 16'h1234, 8'h00, 1'b0);
		check(q, fetch_byte(16'h1234));
		n0 = ale_cnt;
		repeat (120) @(posedge pclk);
		check(ale_cnt - n0 == 20, 1'b1);
		reset_pin <= 1'b1;
		repeat (20) @(posedge pclk);
		check(device_reset, 1'b0);
		repeat (10) @(posedge pclk);
		check(device_reset, 1'b1);
		reset_pin <= 1'b0;
		repeat (3) @(posedge pclk);
		apb(0, mem_access_pkg::CHIP_CONTROL_INDEX, 8'h00);
		check(q, 8'h00);
		wrap_up;
	end
endmodule

// ### tb/ext_memory.sv
`timescale 1ns/10ps
module ext_memory (
	input  wire logic       pclk,
	input  wire logic       ale,
	input  wire logic       ps_n,
	input  wire logic       rd_n,
	input  wire logic       wr_n,
	input  wire logic [7:0] bus_out,
	output logic      [7:0] bus_in
);
	logic [7:0] mem [256];
	logic [7:0] lo;

	initial bus_in = 8'h00;
	// Latch only outside strobes, since the latch strobe free runs
	always @(posedge pclk) begin
		if (ale && ps_n && rd_n && wr_n)
			lo <= bus_out;
		if (!wr_n)
			mem[lo] <= bus_out;
		if (!ps_n)
			bus_in <= lo ^ 8'hc3;
		else if (!rd_n)
			bus_in <= mem[lo];
		else
			bus_in <= ~bus_in;
	end
endmodule
